// ==== core/aperture_delay_defs.svh ====
/*
  Offsets, field positions, reset values and timing counts of the aperture delay control block.
  Assumes it is included by bare name; holds definitions only.
*/
`ifndef APERTURE_DELAY_DEFS_SVH
`define APERTURE_DELAY_DEFS_SVH

// Register byte offsets on the serial control port
`define ADDR_REFCAL_ENABLE        15'h02b0
`define ADDR_REFCAL_STATUS        15'h02b2
`define ADDR_DELAY_MANUAL         15'h02b5
`define ADDR_RAMP_CONTROL         15'h02b8
`define ADDR_MAP_END              15'h02bf

// Field positions
`define DELAY_INV_BIT             16
`define DELAY_COARSE_MSB          15
`define DELAY_COARSE_LSB          8
`define DELAY_FINE_MSB            7
`define DELAY_FINE_LSB            0
`define STATUS_DONE_BIT           17
`define RAMP_EN_BIT               0
`define RAMP_RATE_BIT             1

// Reset values
`define DELAY_MANUAL_RESET        17'h00000
`define RAMP_CONTROL_RESET        2'h0
`define REFCAL_ENABLE_RESET       1'h0

// Timing counts in clock cycles, tick counter width and coarse step sizes
`define RAMP_STEP_CYCLES          384
`define APPLY_LIMIT_CYCLES        1536
`define RAMP_CNT_W                9
`define COARSE_STEP_SLOW          8'h01
`define COARSE_STEP_FAST          8'h04

`endif

// ==== core/aperture_delay_pkg.sv ====
/*
  Types shared by the aperture delay control block.
  Assumes the defs header supplies all numeric constants.
*/
package aperture_delay_pkg;
  typedef logic [16:0] delay_word_t;
  typedef logic [7:0]  delay_code_t;
  typedef enum logic [1:0] {
    SPI_IDLE,
    SPI_ADDR,
    SPI_DATA
  } spi_phase_e;
endpackage

// ==== core/coarse_delay_stepper.sv ====
/*
  Moves the applied coarse code toward a target by a fixed step every 384 cycles when ramping,
  or loads the target on the next step tick when not ramping.
  Assumes a synchronous active-high reset on the single clock.
*/
`timescale 1ns/1ps
`include "aperture_delay_defs.svh"
module coarse_delay_stepper (
  // Clock and reset
  input  wire logic                            mclk_in,
  input  wire logic                            reset_in,
  // Control
  input  wire logic                            ramp_en_in,
  input  wire logic                            ramp_fast_in,
  input  wire aperture_delay_pkg::delay_code_t target_in,
  // Applied code
  output aperture_delay_pkg::delay_code_t      applied_out
);
  import aperture_delay_pkg::*;

  logic [`RAMP_CNT_W-1:0] tick_cnt_r;
  logic                   tick;
  delay_code_t            step;
  delay_code_t            applied_r;
  delay_code_t            gap;

  // Step tick divider, one pulse per 384 cycles
  always_ff @(posedge mclk_in) begin
    if (reset_in || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign tick = (tick_cnt_r == `RAMP_CNT_W'(`RAMP_STEP_CYCLES - 1));

  assign step = ramp_fast_in ? `COARSE_STEP_FAST : `COARSE_STEP_SLOW;
  assign gap  = (target_in > applied_r) ? (target_in - applied_r) : (applied_r - target_in);

  // Without ramping the target lands within 384 cycles, well inside 1536; clamp last step
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      applied_r <= '0;
    end else if (tick) begin
      if (!ramp_en_in || gap <= step) begin
        applied_r <= target_in;
      end else if (target_in > applied_r) begin
        applied_r <= applied_r + step;
      end else begin
        applied_r <= applied_r - step;
      end
    end
  end
  assign applied_out = applied_r;
endmodule

// ==== core/aperture_delay_adjust_control.sv ====
/*
  Aperture delay adjustment control: manual delay, ramp control and reference calibration
  status registers behind a serial control port, and the applied delay outputs.
  Assumes the serial clock is slow next to mclk_in and that the calibration engine outside
  reports its result and a finished level; protocol: 16-bit header (R/W, 15-bit address)
  then 8-bit data, MSB first, with auto-increment while select stays low.
*/
// Operation
// - The completion flag reads one only while calibration is enabled and it has finished.
// - A 17-bit calibrated delay result is readable, valid only while the flag is set.
// - Result bit 16 is inversion, bits 15 to 8 coarse code, bits 7 to 0 fine code.
// - Manual bit 16 set inverts the sampling clock, clear leaves it non-inverted.
// - With calibration off the manual coarse field bits 15 to 8 sets the coarse step.
// - With calibration off the manual fine field bits 7 to 0 sets the fine step.
// - The fine field may change any time and is applied at once without glitch.
// - Calibration off uses the manual register; calibration on ignores it.
// - A zero-to-one change of the calibration enable starts the calibration sequence.
// - Without ramping a new coarse code is applied within 1536 cycles.
// - Ramping moves the coarse code by one, or four with rate set, every 384 cycles.
`timescale 1ns/1ps
`include "aperture_delay_defs.svh"
module aperture_delay_adjust_control (
  // Clock and reset
  input  wire logic                             mclk_in,
  input  wire logic                             reset_in,
  // Serial control port
  input  wire logic                             spi_sclk_in,
  input  wire logic                             spi_csn_in,
  input  wire logic                             spi_sdi_in,
  output logic                                  spi_sdo_out,
  output logic                                  spi_sdo_oen_out,
  // Calibration engine
  input  wire logic                             refcal_finished_in,
  input  wire aperture_delay_pkg::delay_word_t  refcal_result_in,
  output logic                                  refcal_start_out,
  output logic                                  refcal_enable_out,
  // Applied delay
  output logic                                  device_sample_clock_invert_out,
  output aperture_delay_pkg::delay_code_t       coarse_delay_out,
  output aperture_delay_pkg::delay_code_t       fine_delay_out
);
  import aperture_delay_pkg::*;

  logic [2:0]  sclk_sync_r;
  logic [2:0]  csn_sync_r;
  logic [2:0]  sdi_sync_r;
  logic        sclk_lvl_r;
  logic        csn_lvl_r;
  logic        sdi_lvl_r;
  logic        sclk_rise;
  logic        sclk_fall;
  spi_phase_e  phase_r;
  logic [4:0]  bit_cnt_r;
  logic        rd_r;
  logic [14:0] addr_r;
  logic [7:0]  shift_r;
  logic [7:0]  rdata;
  logic        wr_stb;
  logic [7:0]  wdata;
  logic        sdo_r;
  logic        sdo_en_r;
  delay_word_t manual_r;
  logic [1:0]  ramp_ctl_r;
  logic        refcal_en_r;
  logic        refcal_en_d_r;
  logic        refcal_done_r;
  delay_word_t refcal_res_r;
  logic [23:0] status_word;
  delay_code_t coarse_target;
  delay_code_t coarse_applied;
  logic        inv_r;
  delay_code_t fine_r;

  // Pins are asynchronous: three stages, a change counts when stages two and three agree
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sclk_sync_r <= 3'h0;
      csn_sync_r  <= 3'h7;
      sdi_sync_r  <= 3'h0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk_in};
      csn_sync_r  <= {csn_sync_r[1:0], spi_csn_in};
      sdi_sync_r  <= {sdi_sync_r[1:0], spi_sdi_in};
    end
  end

  // Filtered levels
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sclk_lvl_r <= 1'b0;
      csn_lvl_r  <= 1'b1;
      sdi_lvl_r  <= 1'b0;
    end else begin
      if (sclk_sync_r[2] == sclk_sync_r[1]) sclk_lvl_r <= sclk_sync_r[2];
      if (csn_sync_r[2] == csn_sync_r[1])   csn_lvl_r  <= csn_sync_r[2];
      if (sdi_sync_r[2] == sdi_sync_r[1])   sdi_lvl_r  <= sdi_sync_r[2];
    end
  end
  assign sclk_rise = !sclk_lvl_r && (sclk_sync_r[2] == sclk_sync_r[1]) && sclk_sync_r[2];
  assign sclk_fall = sclk_lvl_r && (sclk_sync_r[2] == sclk_sync_r[1]) && !sclk_sync_r[2];

  // Serial frame: header then bytes; a byte completes on its eighth rising edge
  always_ff @(posedge mclk_in) begin
    if (reset_in || csn_lvl_r) begin
      phase_r   <= SPI_IDLE;
      bit_cnt_r <= 5'h00;
      rd_r      <= 1'b0;
      addr_r    <= 15'h0000;
      shift_r   <= 8'h00;
    end else if (sclk_rise) begin
      case (phase_r)
        SPI_IDLE: begin
          rd_r      <= sdi_lvl_r;
          bit_cnt_r <= 5'h01;
          phase_r   <= SPI_ADDR;
        end
        SPI_ADDR: begin
          addr_r <= {addr_r[13:0], sdi_lvl_r};
          if (bit_cnt_r == 5'h0f) begin
            bit_cnt_r <= 5'h00;
            phase_r   <= SPI_DATA;
          end else begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end
        end
        SPI_DATA: begin
          shift_r <= {shift_r[6:0], sdi_lvl_r};
          if (bit_cnt_r == 5'h07) begin
            bit_cnt_r <= 5'h00;
            addr_r    <= addr_r + 15'h0001;   // Auto-increment for streaming
          end else begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end
        end
        default: phase_r <= SPI_IDLE;
      endcase
    end
  end
  assign wr_stb = !csn_lvl_r && sclk_rise && (phase_r == SPI_DATA) && !rd_r
                  && (bit_cnt_r == 5'h07);
  assign wdata  = {shift_r[6:0], sdi_lvl_r};

  // Status word: done flag only while enabled and finished; result valid with the flag
  assign status_word = {6'h00, refcal_done_r & refcal_en_r, refcal_res_r};

  // Read mux, one byte per address, little-endian byte order in multi-byte registers
  always_comb begin
    case (addr_r)
      `ADDR_REFCAL_ENABLE:       rdata = {7'h00, refcal_en_r};
      `ADDR_REFCAL_STATUS:       rdata = status_word[7:0];
      `ADDR_REFCAL_STATUS + 15'h1: rdata = status_word[15:8];
      `ADDR_REFCAL_STATUS + 15'h2: rdata = status_word[23:16];
      `ADDR_DELAY_MANUAL:        rdata = manual_r[7:0];
      `ADDR_DELAY_MANUAL + 15'h1: rdata = manual_r[15:8];
      `ADDR_DELAY_MANUAL + 15'h2: rdata = {7'h00, manual_r[16]};
      `ADDR_RAMP_CONTROL:        rdata = {6'h00, ramp_ctl_r};
      default:                   rdata = 8'h00;
    endcase
  end

  // Read data shifts out on falling edges; the pin is driven only during a read data phase
  always_ff @(posedge mclk_in) begin
    if (reset_in || csn_lvl_r) begin
      sdo_r    <= 1'b0;
      sdo_en_r <= 1'b0;
    end else if (sclk_fall && rd_r && phase_r == SPI_DATA) begin
      sdo_r    <= rdata[3'h7 - bit_cnt_r[2:0]];
      sdo_en_r <= 1'b1;
    end
  end
  assign spi_sdo_out     = sdo_r;
  assign spi_sdo_oen_out = !sdo_en_r;

  // Register writes; inversion timing is the writer's duty, coarse pacing is done by the stepper
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      manual_r    <= `DELAY_MANUAL_RESET;
      ramp_ctl_r  <= `RAMP_CONTROL_RESET;
      refcal_en_r <= `REFCAL_ENABLE_RESET;
    end else if (wr_stb) begin
      case (addr_r)
        `ADDR_REFCAL_ENABLE:          refcal_en_r      <= wdata[0];
        `ADDR_DELAY_MANUAL:           manual_r[7:0]    <= wdata;
        `ADDR_DELAY_MANUAL + 15'h1:   manual_r[15:8]   <= wdata;
        `ADDR_DELAY_MANUAL + 15'h2:   manual_r[16]     <= wdata[0];
        `ADDR_RAMP_CONTROL:           ramp_ctl_r       <= wdata[1:0];
        default:                      ;
      endcase
    end
  end

  // Rising enable starts calibration; done is dropped while disabled, so a re-enable
  // never shows a stale completion for even one cycle
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      refcal_en_d_r <= 1'b0;
      refcal_done_r <= 1'b0;
      refcal_res_r  <= '0;
    end else begin
      refcal_en_d_r <= refcal_en_r;
      if (refcal_en_r && !refcal_en_d_r) begin
        refcal_done_r <= 1'b0;
      end else if (!refcal_en_r) begin
        refcal_done_r <= 1'b0;
      end else if (refcal_en_r && refcal_finished_in && !refcal_done_r) begin
        refcal_done_r <= 1'b1;
        refcal_res_r  <= refcal_result_in;
      end
    end
  end
  assign refcal_start_out  = refcal_en_r && !refcal_en_d_r;
  assign refcal_enable_out = refcal_en_r;

  // Source select: manual register when calibration is off, result when on
  assign coarse_target = refcal_en_r ? refcal_res_r[`DELAY_COARSE_MSB:`DELAY_COARSE_LSB]
                                     : manual_r[`DELAY_COARSE_MSB:`DELAY_COARSE_LSB];

  coarse_delay_stepper u_stepper (
    .mclk_in      (mclk_in),
    .reset_in     (reset_in),
    .ramp_en_in   (ramp_ctl_r[`RAMP_EN_BIT]),
    .ramp_fast_in (ramp_ctl_r[`RAMP_RATE_BIT]),
    .target_in    (coarse_target),
    .applied_out  (coarse_applied)
  );

  // Fine and inversion apply on the next cycle; fine needs no pacing
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      inv_r  <= 1'b0;
      fine_r <= 8'h00;
    end else if (refcal_en_r) begin
      inv_r  <= refcal_res_r[`DELAY_INV_BIT];
      fine_r <= refcal_res_r[`DELAY_FINE_MSB:`DELAY_FINE_LSB];
    end else begin
      inv_r  <= manual_r[`DELAY_INV_BIT];
      fine_r <= manual_r[`DELAY_FINE_MSB:`DELAY_FINE_LSB];
    end
  end
  assign device_sample_clock_invert_out = inv_r;
  assign fine_delay_out                 = fine_r;
  assign coarse_delay_out               = coarse_applied;
endmodule

// ==== bench/aperture_delay_checker_assertions.sv ====
/*
  Port-level checker for aperture_delay_adjust_control.
  Assumes one mclk_in domain with synchronous active-high reset_in; bound to every instance.
*/
`timescale 1ns/1ps
module aperture_delay_checker (
  // Clock and reset
  input wire logic                            mclk_in,
  input wire logic                            reset_in,
  // Observed ports
  input wire logic                            spi_csn_in,
  input wire logic                            spi_sdo_oen_out,
  input wire logic                            refcal_finished_in,
  input wire aperture_delay_pkg::delay_word_t refcal_result_in,
  input wire logic                            refcal_start_out,
  input wire logic                            refcal_enable_out,
  input wire logic                            device_sample_clock_invert_out,
  input wire aperture_delay_pkg::delay_code_t coarse_delay_out,
  input wire aperture_delay_pkg::delay_code_t fine_delay_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  // Calibration start follows the enable edge exactly, and only for one cycle
  start_pulse_a: assert property (refcal_start_out == $rose(refcal_enable_out))
    else $error("start pulse does not match enable rise");
  start_once_a: assert property (refcal_start_out |=> !refcal_start_out)
    else $error("start pulse longer than one cycle");
  enable_hold_a: assert property (spi_csn_in [*8] |=> $stable(refcal_enable_out))
    else $error("calibration enable moved without a frame");
  // Read driver must be released once the port is deselected
  oen_idle_a: assert property (spi_csn_in [*6] |-> spi_sdo_oen_out)
    else $error("serial output still driven while deselected");
  // Finished calibration drives the applied fine code and inversion from its result
  cal_fine_a: assert property ((refcal_enable_out && refcal_finished_in) [*4] |->
    fine_delay_out == refcal_result_in[7:0]) else $error("fine code not from result");
  cal_inv_a: assert property ((refcal_enable_out && refcal_finished_in) [*4] |->
    device_sample_clock_invert_out == refcal_result_in[16]) else $error("inversion not from result");
  // Manual outputs change only through register writes
  manual_hold_a: assert property ((spi_csn_in && !refcal_enable_out) [*8] |=>
    $stable(fine_delay_out) && $stable(device_sample_clock_invert_out))
    else $error("manual delay changed without a write");
  // Coarse code moves only on the 384-cycle tick
  coarse_hold_a: assert property ($changed(coarse_delay_out) && $stable(refcal_enable_out) |=>
    $stable(coarse_delay_out) [*8]) else $error("coarse code moved between ticks");
endmodule

bind aperture_delay_adjust_control aperture_delay_checker aperture_delay_checker_i (
  .mclk_in(mclk_in), .reset_in(reset_in), .spi_csn_in(spi_csn_in),
  .spi_sdo_oen_out(spi_sdo_oen_out), .refcal_finished_in(refcal_finished_in),
  .refcal_result_in(refcal_result_in), .refcal_start_out(refcal_start_out),
  .refcal_enable_out(refcal_enable_out), .coarse_delay_out(coarse_delay_out),
  .device_sample_clock_invert_out(device_sample_clock_invert_out),
  .fine_delay_out(fine_delay_out));

// ==== bench/testbench.sv ====
/*
  Self-checking bench for aperture_delay_adjust_control.
  Assumes the serial frame of the design notes; the bench drives all ports directly.
*/
`timescale 1ns/1ps
`include "aperture_delay_defs.svh"
module testbench;
  import aperture_delay_pkg::*;
  logic        mclk_in            = 1'b0;
  logic        reset_in           = 1'b1;
  logic        spi_sclk_in        = 1'b0;
  logic        spi_csn_in         = 1'b1;
  logic        spi_sdi_in         = 1'b0;
  logic        refcal_finished_in = 1'b0;
  delay_word_t refcal_result_in   = 17'h00000;
  logic        spi_sdo_out, spi_sdo_oen_out, refcal_start_out, refcal_enable_out;
  logic        device_sample_clock_invert_out;
  delay_code_t coarse_delay_out, fine_delay_out;
  logic [7:0]  rd;
  logic        oen_seen;
  int          n_mismatch = 0;
  int          checks     = 0;

  // 40 MHz clock
  always #12.5 mclk_in = ~mclk_in;

  aperture_delay_adjust_control aperture_delay_adjust_control_i (
    .mclk_in(mclk_in), .reset_in(reset_in), .spi_sclk_in(spi_sclk_in),
    .spi_csn_in(spi_csn_in), .spi_sdi_in(spi_sdi_in), .spi_sdo_out(spi_sdo_out),
    .spi_sdo_oen_out(spi_sdo_oen_out), .refcal_finished_in(refcal_finished_in),
    .refcal_result_in(refcal_result_in), .refcal_start_out(refcal_start_out),
    .refcal_enable_out(refcal_enable_out), .coarse_delay_out(coarse_delay_out),
    .device_sample_clock_invert_out(device_sample_clock_invert_out),
    .fine_delay_out(fine_delay_out));

  // Inputs always change 2 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask

  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One frame; half periods of 8 cycles leave room for the input synchroniser
  task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] wd);
    logic [23:0] f;
    f = {rw, a, wd};
    spi_csn_in = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi_in = f[i];
      cyc(8);
      if (i < 8) rd[i] = spi_sdo_out;
      if (i == 0) oen_seen = spi_sdo_oen_out;
      spi_sclk_in = 1'b1;
      cyc(8);
      spi_sclk_in = 1'b0;
    end
    cyc(8);
    spi_csn_in = 1'b1;
    cyc(8);
  endtask

  task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    chk($sformatf("reg %h", a), {9'h000, e}, {9'h000, rd});
    chk("sdo enable", 17'h00000, {16'h0000, oen_seen});
  endtask

  // Bounded wait for the applied coarse code; a skipped value runs out the bound
  task automatic wait_coarse(input logic [7:0] e, input int n);
    for (int i = 0; i < n && coarse_delay_out !== e; i++) cyc(1);
    chk("coarse", {9'h000, e}, {9'h000, coarse_delay_out});
  endtask

  task automatic t_reset();
    rdchk(`ADDR_DELAY_MANUAL, 8'h00);
    rdchk(`ADDR_DELAY_MANUAL + 15'h0001, 8'h00);
    rdchk(`ADDR_RAMP_CONTROL, 8'h00);
    rdchk(`ADDR_REFCAL_ENABLE, 8'h00);
    chk("outputs", 17'h00000, {device_sample_clock_invert_out, coarse_delay_out, fine_delay_out});
  endtask

  task automatic t_manual();
    xfer(1'b0, `ADDR_DELAY_MANUAL, 8'h5a);
    chk("fine", 17'h0005a, {9'h000, fine_delay_out});
    xfer(1'b0, `ADDR_DELAY_MANUAL, 8'ha5);
    chk("fine", 17'h000a5, {9'h000, fine_delay_out});
    xfer(1'b0, `ADDR_DELAY_MANUAL + 15'h0001, 8'h37);
    wait_coarse(8'h37, `APPLY_LIMIT_CYCLES);
    xfer(1'b0, `ADDR_DELAY_MANUAL + 15'h0002, 8'hff);
    chk("invert", 17'h00001, {16'h0000, device_sample_clock_invert_out});
    rdchk(`ADDR_DELAY_MANUAL + 15'h0002, 8'h01);
    xfer(1'b0, `ADDR_DELAY_MANUAL + 15'h0002, 8'h00);
    chk("invert", 17'h00000, {16'h0000, device_sample_clock_invert_out});
    rdchk(`ADDR_DELAY_MANUAL + 15'h0001, 8'h37);
    rdchk(`ADDR_MAP_END, 8'h00);
  endtask

  // Slow ramp must pass every code, fast ramp every fourth
  task automatic t_ramp();
    xfer(1'b0, `ADDR_RAMP_CONTROL, 8'h01);
    rdchk(`ADDR_RAMP_CONTROL, 8'h01);
    xfer(1'b0, `ADDR_DELAY_MANUAL + 15'h0001, 8'h3a);
    for (int k = 1; k <= 3; k++) wait_coarse(8'h37 + 8'(k), 400);
    xfer(1'b0, `ADDR_RAMP_CONTROL, 8'h03);
    xfer(1'b0, `ADDR_DELAY_MANUAL + 15'h0001, 8'h2a);
    for (int k = 1; k <= 4; k++) wait_coarse(8'h3a - 8'(4 * k), 400);
    xfer(1'b0, `ADDR_RAMP_CONTROL, 8'h00);
  endtask

  task automatic t_cal();
    refcal_result_in = 17'h1a5c3;
    xfer(1'b0, `ADDR_REFCAL_ENABLE, 8'h01);
    chk("enable", 17'h00001, {16'h0000, refcal_enable_out});
    rdchk(`ADDR_REFCAL_STATUS + 15'h0002, 8'h00);
    refcal_finished_in = 1'b1;
    cyc(4);
    rdchk(`ADDR_REFCAL_STATUS, 8'hc3);
    rdchk(`ADDR_REFCAL_STATUS + 15'h0001, 8'ha5);
    rdchk(`ADDR_REFCAL_STATUS + 15'h0002, 8'h03);
    wait_coarse(8'ha5, 400);
    xfer(1'b0, `ADDR_DELAY_MANUAL, 8'h11);
    chk("cal delay", 17'h1a5c3, {device_sample_clock_invert_out, coarse_delay_out, fine_delay_out});
    xfer(1'b0, `ADDR_REFCAL_ENABLE, 8'h00);
    // Flag drops with the enable; bit 16 of the last result stays readable
    rdchk(`ADDR_REFCAL_STATUS + 15'h0002, 8'h01);
    chk("fine", 17'h00011, {9'h000, fine_delay_out});
    refcal_finished_in = 1'b0;
  endtask

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs about 14000 cycles
  initial begin
    cyc(60000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    cyc(4);
    reset_in = 1'b0;
    cyc(4);
    t_reset();
    t_manual();
    t_ramp();
    t_cal();
    finish_test();
  end
endmodule
